// ### pkg/amlm_pkg.sv
// amlm_pkg: constants and carrier types of the four-channel audio mixer
// and level meter. Assumes 24-bit signed samples in two's complement and
// level thresholds given as sample magnitudes against full scale 2^23.
package amlm_pkg;
  localparam int NCH       = 4;                 // channels and output buses
  localparam int SMP_W     = 24;                // sample width
  localparam int GAIN_W    = 16;                // gain word, unsigned Q4.12
  localparam int GAIN_FRAC = 12;                // fraction bits of the gain
  localparam logic [15:0] GAIN_UNITY = 16'h1000; // 0 dB

  // sample timing; the converter strobes one frame per sample period
  localparam int unsigned SAMPLE_RATE_HZ = 48000;
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned CLK_PER_SMP    = CLK_HZ / SAMPLE_RATE_HZ;

  // peak threshold choices
  localparam logic [2:0] PK_CLIP = 3'h0;
  localparam logic [2:0] PK_2DB  = 3'h1;
  localparam logic [2:0] PK_4DB  = 3'h2;
  localparam logic [2:0] PK_6DB  = 3'h3;
  localparam logic [2:0] PK_8DB  = 3'h4;
  localparam logic [2:0] PK_10DB = 3'h5;

  // magnitude thresholds, full scale = 0x800000
  localparam logic [23:0] THR_CLIP  = 24'h7FFFFF; // full scale
  localparam logic [23:0] THR_2DB   = 24'h65AC8B; // -2 dBFS
  localparam logic [23:0] THR_4DB   = 24'h50C335; // -4 dBFS
  localparam logic [23:0] THR_6DB   = 24'h4026E7; // -6 dBFS
  localparam logic [23:0] THR_8DB   = 24'h32F52D; // -8 dBFS
  localparam logic [23:0] THR_10DB  = 24'h287A27; // -10 dBFS
  localparam logic [23:0] VU0_REF20 = 24'h0CCCCD; // 0 VU at -20 dBFS
  localparam logic [23:0] VU0_REF18 = 24'h101D3F; // 0 VU at -18 dBFS
  localparam logic [23:0] VUM20_R20 = 24'h0147AE; // -20 VU at -40 dBFS
  localparam logic [23:0] VUM20_R18 = 24'h019C86; // -20 VU at -38 dBFS

  typedef logic signed [23:0] amlm_smp_t;

  // one sample frame: all four channels at once
  typedef struct packed {
    logic                 valid;
    amlm_smp_t [NCH-1:0]  ch;
  } amlm_frame_t;

  // static configuration levels
  typedef struct packed {
    logic [NCH-1:0][NCH-1:0] route;   // route[input] = bus mask
    logic [NCH-1:0]          invert;  // phase invert per input
    logic                    tie12;   // pair 1/2 shares controls
    logic                    tie34;   // pair 3/4 shares controls
    logic [1:0]              groupSel; // embed group, 0..3 = group 1..4
    logic                    digRef;  // 0: -20 dBFS, 1: -18 dBFS
    logic                    anaRef;  // 0: -10 dBu, 1: +4 dBu
    logic [2:0]              peakSel; // peak threshold choice
  } amlm_cfg_t;

  // gain commands, one-cycle strobes sharing one value
  typedef struct packed {
    logic [NCH-1:0]    gainWr;     // load gainVal into a channel
    logic [NCH-1:0]    defaultCmd; // restore a channel to unity
    logic [GAIN_W-1:0] gainVal;    // new gain, Q4.12
  } amlm_gaincmd_t;

  // level flags of one output bus
  typedef struct packed {
    logic peak;      // at or above headroom threshold
    logic vuOrange;  // above 0 VU
    logic vuGreen;   // above -20 VU, not above 0 VU
  } amlm_meter_t;
endpackage

// ### rtl/amlm_meter.sv
// amlm_meter: peak and VU flags for one output bus.
// Assumes the sample and its strobe come from flip-flops of the mixer.
`timescale 1ns/1ps
module amlm_meter (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire amlm_pkg::amlm_smp_t  smp,
  input  wire logic                 smpValid,
  input  wire logic                 digRef,
  input  wire logic [2:0]           peakSel,
  output amlm_pkg::amlm_meter_t     level
);
  typedef struct packed {
    amlm_pkg::amlm_meter_t level; // flags of the latest sample
  } amlm_met_st_t;

  amlm_met_st_t s_q;            // registered state
  amlm_met_st_t s_d;            // next state
  logic [23:0]  mag;            // sample magnitude
  logic [23:0]  peakThr;        // chosen peak threshold
  logic [23:0]  vu0Thr;         // 0 VU threshold
  logic [23:0]  vu20Thr;        // -20 VU threshold

  // magnitude; the most negative sample maps to 0x800000, no wrap
  assign mag = smp[23] ? 24'(-smp) : 24'(smp);

  // thresholds from headroom and reference settings
  always_comb begin
    case (peakSel)
      amlm_pkg::PK_2DB:  peakThr = amlm_pkg::THR_2DB;
      amlm_pkg::PK_4DB:  peakThr = amlm_pkg::THR_4DB;
      amlm_pkg::PK_6DB:  peakThr = amlm_pkg::THR_6DB;
      amlm_pkg::PK_8DB:  peakThr = amlm_pkg::THR_8DB;
      amlm_pkg::PK_10DB: peakThr = amlm_pkg::THR_10DB;
      default:           peakThr = amlm_pkg::THR_CLIP;  // clipping
    endcase
    // 0 VU tracks the digital reference level
    vu0Thr  = digRef ? amlm_pkg::VU0_REF18 : amlm_pkg::VU0_REF20;
    vu20Thr = digRef ? amlm_pkg::VUM20_R18 : amlm_pkg::VUM20_R20;
  end

  // flags follow each new sample and hold between samples
  always_comb begin
    s_d = s_q;
    if (smpValid) begin
      s_d.level.peak     = (mag >= peakThr);
      s_d.level.vuOrange = (mag > vu0Thr);
      s_d.level.vuGreen  = (mag > vu20Thr) && !(mag > vu0Thr);
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;

  peak_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    smpValid |=> level.peak == ($past(mag) >= $past(peakThr)))
    else $error("peak flag does not match threshold");
  vu_bands_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(level.vuOrange && level.vuGreen))
    else $error("both VU bands lit");
  vu_ref_a: assert property (@(posedge clk) disable iff (!reset_n)
    smpValid && digRef && mag > amlm_pkg::VU0_REF18 |=> level.vuOrange)
    else $error("0 VU not at -18 dBFS reference");
  flag_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !smpValid |=> $stable(level))
    else $error("flags changed without a sample");
endmodule // amlm_meter

// ### rtl/amlm_mixer.sv
// amlm_mixer: four-channel audio mixer with gain, invert, tie, routing
// and per-bus level meters, feeding an SDI audio embedder.
// Assumes inFrame is synchronous to clk, one valid strobe per sample,
// and gain commands are one-cycle strobes.
`timescale 1ns/1ps
module amlm_mixer (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire amlm_pkg::amlm_frame_t      inFrame,
  input  wire amlm_pkg::amlm_cfg_t        cfg,
  input  wire amlm_pkg::amlm_gaincmd_t    gainCmd,
  output amlm_pkg::amlm_frame_t           outFrame,
  output logic [1:0]                      outGroup,
  output logic                            outAnaRef,
  output amlm_pkg::amlm_meter_t [3:0]     level
);
  typedef struct packed {
    logic [3:0][15:0]       gain;   // stored gain per input
    amlm_pkg::amlm_frame_t  st1;    // after gain and invert
    amlm_pkg::amlm_frame_t  out;    // mixed bus samples
    logic [1:0]             group;  // group tag of out
    logic                   anaRef; // analog reference tag of out
  } amlm_mix_st_t;

  amlm_mix_st_t s_q;            // registered state
  amlm_mix_st_t s_d;            // next state

  // clamp a wide signed value into 24 bits
  function automatic amlm_pkg::amlm_smp_t sat24(
    input logic signed [41:0] v);
    if (v[41:23] != {19{v[41]}}) begin
      sat24 = v[41] ? 24'sh800000 : 24'sh7FFFFF;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // index of the channel whose controls steer channel i
  function automatic int ctrlSrc(input int i, input logic t12,
                                 input logic t34);
    if ((i == 1 && t12) || (i == 3 && t34)) begin
      ctrlSrc = i - 1;
    end else begin
      ctrlSrc = i;
    end
  endfunction

  // next state: gain commands, gain stage, bus summing
  always_comb begin
    logic signed [41:0] prod;
    logic signed [41:0] acc;
    logic               tie;
    int                 src;
    s_d  = s_q;
    prod = '0;
    acc  = '0;
    tie  = 1'b0;
    src  = 0;
    // gain commands; a tied partner's command lands on both
    for (int i = 0; i < 4; i++) begin
      tie = (i < 2) ? cfg.tie12 : cfg.tie34;
      if (gainCmd.defaultCmd[i] ||
          (tie && gainCmd.defaultCmd[i ^ 1])) begin
        s_d.gain[i] = amlm_pkg::GAIN_UNITY;
      end else if (gainCmd.gainWr[i] ||
                   (tie && gainCmd.gainWr[i ^ 1])) begin
        s_d.gain[i] = gainCmd.gainVal;
      end
    end
    // stage one: gain, then optional phase invert
    s_d.st1.valid = inFrame.valid;
    if (inFrame.valid) begin
      for (int i = 0; i < 4; i++) begin
        src  = ctrlSrc(i, cfg.tie12, cfg.tie34);
        prod = 42'($signed({{18{inFrame.ch[i][23]}}, inFrame.ch[i]})
               * $signed({26'h0, s_q.gain[src]}));
        prod = prod >>> amlm_pkg::GAIN_FRAC;
        if (cfg.invert[src]) begin
          prod = -prod;
        end
        s_d.st1.ch[i] = sat24(prod);
      end
    end
    // stage two: sum routed inputs onto each bus
    s_d.out.valid = s_q.st1.valid;
    if (s_q.st1.valid) begin
      for (int b = 0; b < 4; b++) begin
        acc = '0;
        for (int i = 0; i < 4; i++) begin
          src = ctrlSrc(i, cfg.tie12, cfg.tie34);
          if (cfg.route[src][b]) begin
            acc = acc + 42'(s_q.st1.ch[i]);
          end
        end
        s_d.out.ch[b] = sat24(acc);
      end
      s_d.group  = cfg.groupSel;
      s_d.anaRef = cfg.anaRef;
    end
  end

  // state register; gains start at unity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q      <= '0;
      s_q.gain <= {4{amlm_pkg::GAIN_UNITY}};
    end else begin
      s_q <= s_d;
    end
  end

  assign outFrame  = s_q.out;
  assign outGroup  = s_q.group;
  assign outAnaRef = s_q.anaRef;

  // one meter per output bus, each channel on its own
  for (genvar b = 0; b < 4; b++) begin : g_meter
    amlm_meter u_meter (
      .clk      (clk),
      .reset_n  (reset_n),
      .smp      (s_q.out.ch[b]),
      .smpValid (s_q.out.valid),
      .digRef   (cfg.digRef),
      .peakSel  (cfg.peakSel),
      .level    (level[b])
    );
  end

  sequence defaultSeq;
    gainCmd.defaultCmd[0] ##1 1'b1;
  endsequence
  sequence frameSeq;
    inFrame.valid ##2 outFrame.valid;
  endsequence

  gain_default_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    defaultSeq |-> s_q.gain[0] == amlm_pkg::GAIN_UNITY)
    else $error("default did not restore unity gain");
  gain_load_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    gainCmd.gainWr[2] && !gainCmd.defaultCmd[2] && !cfg.tie34
    |=> s_q.gain[2] == $past(gainCmd.gainVal))
    else $error("gain value not loaded");
  phase_invert_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    inFrame.valid && cfg.invert[2] && !cfg.tie34
    && s_q.gain[2] == amlm_pkg::GAIN_UNITY
    && inFrame.ch[2] != 24'sh800000
    |=> s_q.st1.ch[2] == -$past(inFrame.ch[2]))
    else $error("inverted sample is not negated");
  tie_pair_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    inFrame.valid && cfg.tie12 && inFrame.ch[0] == inFrame.ch[1]
    |=> s_q.st1.ch[0] == s_q.st1.ch[1])
    else $error("tied pair processed differently");
  route_bus_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    s_q.st1.valid && !cfg.tie12 && cfg.route == 16'h0004
    |=> outFrame.ch[2] == $past(s_q.st1.ch[0]))
    else $error("input not routed to chosen bus");
  sum_sat_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    s_q.st1.valid && cfg.route == 16'h1111 && !s_q.st1.ch[0][23]
    && !s_q.st1.ch[1][23] && !s_q.st1.ch[2][23] && !s_q.st1.ch[3][23]
    |=> !outFrame.ch[0][23])
    else $error("bus sum wrapped around");
  group_tag_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    s_q.st1.valid |=> outGroup == $past(cfg.groupSel)
    && outAnaRef == $past(cfg.anaRef))
    else $error("group tag does not follow selection");
  frame_pass_a: assert property (@(posedge clk)
    disable iff (!reset_n)
    inFrame.valid |-> frameSeq)
    else $error("sample frame lost in pipeline");
endmodule // amlm_mixer

// ### tb/amlm_conv_model.sv
// amlm_conv_model: four-channel converter that hands frames to the mixer.
// Assumes the bench asks for each frame with a one-cycle fire strobe.
`timescale 1ns/1ps
module amlm_conv_model (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      fire,
  input  wire amlm_pkg::amlm_smp_t [3:0] smpIn,
  output amlm_pkg::amlm_frame_t          frame
);
  // one strobe per sample; data toggles between frames, never stale
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame <= '0;
    end else begin
      frame.valid <= fire;
      frame.ch    <= fire ? smpIn : ~frame.ch;
    end
  end
endmodule // amlm_conv_model

// ### tb/tb.sv
// tb: self-checking bench of the four-channel mixer and level meter.
// Assumes bus samples two cycles after a frame, flags one cycle later.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    amlm_pkg::amlm_smp_t [3:0]   ch;  // bus samples
    logic [1:0]                  grp; // group tag
    logic                        ana; // analog reference tag
    amlm_pkg::amlm_meter_t [3:0] lv;  // bus flags
  } amlm_exp_t;
  logic                        clk;
  logic                        reset_n;
  logic                        fire;     // frame request to converter
  amlm_pkg::amlm_smp_t [3:0]   smpIn;    // samples of that frame
  amlm_pkg::amlm_smp_t [3:0]   rs;       // random samples
  amlm_pkg::amlm_frame_t       inFrame;
  amlm_pkg::amlm_cfg_t         cfg;
  amlm_pkg::amlm_cfg_t         nc;       // next configuration
  amlm_pkg::amlm_gaincmd_t     gainCmd;
  amlm_pkg::amlm_frame_t       outFrame;
  logic [1:0]                  outGroup;
  logic                        outAnaRef;
  amlm_pkg::amlm_meter_t [3:0] level;
  logic [15:0]                 gain [4]; // expected stored gains
  amlm_exp_t                   expQ [$]; // pending results
  amlm_exp_t                   e;
  int                          miscompares;
  int                          comparisons;
  int                          seed;
  int                          r;
  amlm_conv_model conv (.clk(clk), .reset_n(reset_n), .fire(fire),
                        .smpIn(smpIn), .frame(inFrame));
  amlm_mixer DUT (.clk(clk), .reset_n(reset_n), .inFrame(inFrame),
                  .cfg(cfg), .gainCmd(gainCmd), .outFrame(outFrame),
                  .outGroup(outGroup), .outAnaRef(outAnaRef), .level(level));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [96:0] seen, input logic [96:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic longint sat(input longint v);
    if (v > 64'sh7FFFFF) return 64'sh7FFFFF;
    return v < -64'sh800000 ? -64'sh800000 : v;
  endfunction
  // expected buses and flags from current configuration and gains
  function automatic amlm_exp_t predict(input amlm_pkg::amlm_smp_t [3:0] x);
    amlm_exp_t   p;
    longint      s1 [4];
    longint      acc;
    int          src [4];
    logic [23:0] mag;
    logic [23:0] thr;
    logic [23:0] vu0;
    logic [23:0] vu20;
    p.grp = cfg.groupSel;
    p.ana = cfg.anaRef;
    for (int i = 0; i < 4; i++) begin
      src[i] = ((i == 1 && cfg.tie12) || (i == 3 && cfg.tie34)) ? i - 1 : i;
      s1[i] = (longint'(x[i]) * longint'(gain[src[i]])) >>> 12;
      // invert acts on the unclipped product, clipping happens once after
      if (cfg.invert[src[i]]) s1[i] = -s1[i];
      s1[i] = sat(s1[i]);
    end
    case (cfg.peakSel)
      amlm_pkg::PK_2DB:  thr = amlm_pkg::THR_2DB;
      amlm_pkg::PK_4DB:  thr = amlm_pkg::THR_4DB;
      amlm_pkg::PK_6DB:  thr = amlm_pkg::THR_6DB;
      amlm_pkg::PK_8DB:  thr = amlm_pkg::THR_8DB;
      amlm_pkg::PK_10DB: thr = amlm_pkg::THR_10DB;
      default:           thr = amlm_pkg::THR_CLIP;
    endcase
    vu0 = cfg.digRef ? amlm_pkg::VU0_REF18 : amlm_pkg::VU0_REF20;
    vu20 = cfg.digRef ? amlm_pkg::VUM20_R18 : amlm_pkg::VUM20_R20;
    for (int b = 0; b < 4; b++) begin
      acc = 0;
      for (int i = 0; i < 4; i++)
        if (cfg.route[src[i]][b]) acc += s1[i];
      acc = sat(acc);
      p.ch[b] = 24'(acc);
      mag = 24'(acc < 0 ? -acc : acc);
      p.lv[b].peak = mag >= thr;
      p.lv[b].vuOrange = mag > vu0;
      p.lv[b].vuGreen = mag > vu20 && !(mag > vu0);
    end
    return p;
  endfunction
  task automatic set_cfg;
    @(posedge clk);
    cfg <= nc;
  endtask
  // gain command strobe; a tied pair loads both, default beats write
  task automatic gcmd(input logic [3:0] wr, input logic [3:0] df,
                      input logic [15:0] v);
    logic t;
    @(posedge clk);
    gainCmd <= {wr, df, v};
    for (int i = 0; i < 4; i++) begin
      t = i < 2 ? cfg.tie12 : cfg.tie34;
      if (df[i] || (t && df[i^1])) gain[i] = 16'h1000;
      else if (wr[i] || (t && wr[i^1])) gain[i] = v;
    end
    @(posedge clk);
    gainCmd <= '0;
  endtask
  task automatic send(input amlm_pkg::amlm_smp_t [3:0] s);
    @(posedge clk);
    expQ.push_back(predict(s));
    fire <= 1'b1;
    smpIn <= s;
    @(posedge clk);
    fire <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // monitor: takes the oldest note whenever a bus frame appears
  initial begin
    forever begin
      @(negedge clk);
      if (outFrame.valid === 1'b1) begin
        e = expQ.pop_front();
        check(97'(outFrame.ch), 97'(e.ch));
        check(97'(outGroup), 97'(e.grp));
        check(97'(outAnaRef), 97'(e.ana));
        @(negedge clk);
        check(97'(level), 97'(e.lv));
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
  initial begin
    seed = 32'h3FCD0FB0;
    reset_n = 1'b0;
    fire = 1'b0;
    smpIn = '0;
    cfg = '0;
    nc = '0;
    gainCmd = '0;
    for (int i = 0; i < 4; i++) gain[i] = 16'h1000;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check(outFrame, 97'h0);
    check(97'(level), 97'h0);
    nc.route = 16'h8421;
    nc.groupSel = 2'h2;
    nc.anaRef = 1'b1;
    set_cfg();
    send({24'h0147AE, 24'h0CCCCD, 24'h0CCCCE, 24'h7FFFFF});
    send({24'h800000, 24'hFE0000, 24'h0147AF, 24'h0CCCCC});
    nc.digRef = 1'b1;
    set_cfg();
    send({24'h019C86, 24'h019C87, 24'h0CCCCE, 24'h101D40});
    $display("test levels done");
    for (int p = 0; p < 8; p++) begin
      nc.peakSel = 3'(p);
      set_cfg();
      send({amlm_pkg::THR_10DB, amlm_pkg::THR_6DB, amlm_pkg::THR_4DB - 24'h1,
            amlm_pkg::THR_2DB});
    end
    $display("test peak done");
    nc.invert = 4'h1;
    nc.route = 16'h1F31;
    nc.groupSel = 2'h3;
    set_cfg();
    send({24'h000010, 24'h000001, 24'h400000, 24'h800000});
    $display("test invert done");
    nc = '0;
    nc.route = 16'h8421;
    nc.tie12 = 1'b1;
    set_cfg();
    gcmd(4'h2, 4'h0, 16'h0800);
    gcmd(4'h4, 4'h4, 16'h3000);
    gcmd(4'h8, 4'h0, 16'h2000);
    send({24'h500000, 24'h123456, 24'hF00000, 24'h7FFFFF});
    gcmd(4'h0, 4'h2, 16'h0000);
    send({24'h500000, 24'h123456, 24'hF00000, 24'h7FFFFF});
    $display("test gain done");
    // single route to bus 2 with invert on input 2, then all onto bus 0
    nc = '0;
    nc.route = 16'h0004;
    nc.invert = 4'h4;
    set_cfg();
    send({24'h000123, 24'h7FF000, 24'h234567, 24'h345678});
    nc.route = 16'h1111;
    nc.invert = 4'h0;
    set_cfg();
    send({24'h700000, 24'h600000, 24'h500000, 24'h400000});
    $display("test route done");
    for (int n = 0; n < 40; n++) begin
      nc = amlm_pkg::amlm_cfg_t'(29'($random(seed)));
      set_cfg();
      r = $random(seed);
      gcmd(4'h1 << r[1:0], r[4] ? 4'h1 << r[1:0] : 4'h0,
           16'(r >>> 16) & 16'h3FFF);
      for (int i = 0; i < 4; i++) begin
        r = $random(seed);
        rs[i] = amlm_pkg::amlm_smp_t'(r[23:0]) >>> r[27:24];
      end
      send(rs);
    end
    $display("test random done");
    repeat (8) @(posedge clk);
    check(97'(expQ.size()), 97'h0);
    print_verdict;
  end
endmodule // tb
